// [test_ctrl_pkg.sv]
// constants for the ram self-test and loopback test control block
package test_ctrl_pkg;
    // register indices (byte address = 4 * index)
    localparam logic [5:0] IDX_TEST_CONTROL = 6'h17;
    localparam logic [5:0] IDX_LOOP_TX_DATA = 6'h18;
    localparam logic [5:0] IDX_LOOP_RX_DATA = 6'h19;
    localparam logic [5:0] IDX_FAIL_CLUE    = 6'h1E;
    localparam logic [5:0] IDX_IRQ_STATUS   = 6'h20;
    localparam logic [5:0] IDX_IRQ_MASK     = 6'h21;
    // test_control field positions
    localparam int BIT_MT_ENABLE  = 15;
    localparam int BIT_PAT_LO     = 11;
    localparam int BIT_MT_START   = 10;
    localparam int BIT_MT_PASS    = 9;
    localparam int BIT_MT_FAIL    = 8;
    localparam int BIT_LB_ANALOG  = 5;
    localparam int BIT_LB_SYNC    = 4;
    localparam int BIT_LB_BUS     = 3;
    localparam int BIT_LB_START   = 2;
    localparam int BIT_LB_PASS    = 1;
    localparam int BIT_LB_FAIL    = 0;
    // interrupt status field positions
    localparam int IRQ_MT_DONE    = 0;
    localparam int IRQ_LB_DONE    = 1;
    localparam int IRQ_BITS       = 2;
    // reset values
    localparam logic [15:0] RST_WORD = 16'h0000;
    // memory geometry: four quadrants of 0x2000 words each
    localparam int QUADS          = 4;
    localparam int QUAD_AW        = 13;
    localparam int PAT_COUNT      = 4;
    // timing
    localparam int CLK_PERIOD_PS  = 5000;
    localparam int LB_TIMEOUT_US  = 40;
    localparam int LB_TIMEOUT_CYC = (LB_TIMEOUT_US * 1000000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // march data patterns applied at each address
    function automatic logic [15:0] pattern(input logic [1:0] idx);
        case (idx)
            2'h0:    pattern = 16'h0000;
            2'h1:    pattern = 16'h5555;
            2'h2:    pattern = 16'hAAAA;
            default: pattern = 16'hFFFF;
        endcase
    endfunction
endpackage

// [test_ctrl.sv]
// ram self-test result and loopback test control with ahb-lite registers
// What this block does
// [R01] memtest pass flag sets when the memory test ends error-free
// [R02] memtest fail flag sets on any error during the memory test
// [R03] memtest pass and fail clear when the memtest start bit sets
// [R04] the memory test checks all four quadrants in parallel
// [R05] fail clue register holds lowest-quadrant address under test at failure
// [R06] control bits seven and six cannot be set and read zero
// [R07] digital loopback drives no bus; analog loopback transmits and receives on it
// [R08] loopback word uses command sync when sync select high, else data sync
// [R09] loopback uses bus A when bus select low, bus B when high
// [R10] loopback start launches the configured test, only settable with test pin high
// [R11] loopback start bit clears itself when the test completes
// [R12] loop pass flag sets when the loopback test ends error-free
// [R13] loop fail flag on manchester, parity, sync or data mismatch error
// [R14] loop pass and fail clear when the loopback start bit sets
// [R15] memtest start settable only with test pin high and bit 15 set; self-clears
// [R16] transmitted loopback word comes from the loopback transmit data register
// [R17] received loopback word is written to the loopback receive data register
// [R18] each finished run sets exactly one of its pass and fail flags
//
// Register access over AHB-Lite was chosen for this implementation.
`timescale 1ns/1ps
module test_ctrl #(
    parameter int                                LB_TIMEOUT   = test_ctrl_pkg::LB_TIMEOUT_CYC,
    // last quadrant offset swept; a short sweep keeps simulation cheap
    parameter logic [test_ctrl_pkg::QUAD_AW-1:0] MT_LAST_ADDR = '1
) (
    // clock and reset
    input  wire logic                                      hclk,
    input  wire logic                                      hresetn,
    // ahb-lite slave
    input  wire logic                                      hsel,
    input  wire logic [31:0]                               haddr,
    input  wire logic [1:0]                                htrans,
    input  wire logic                                      hwrite,
    input  wire logic [2:0]                                hsize,
    input  wire logic                                      hready,
    input  wire logic [31:0]                               hwdata,
    output logic [31:0]                                    hrdata,
    output logic                                           hreadyout,
    output logic                                           hresp,
    // test pin from outside
    input  wire logic                                      test_pin,
    // memory test port, one address shared by the four quadrants
    output logic [test_ctrl_pkg::QUAD_AW-1:0]              ram_addr,
    output logic                                           ram_we,
    output logic                                           ram_re,
    output logic [15:0]                                    ram_wdata,
    input  wire logic [test_ctrl_pkg::QUADS-1:0][15:0]     ram_rdata,
    // loopback encoder side
    output logic                                           lb_tx_start,
    output logic [15:0]                                    lb_tx_word,
    output logic                                           lb_tx_cmd_sync,
    output logic                                           lb_bus_a_drive,
    output logic                                           lb_bus_b_drive,
    output logic                                           lb_internal_wrap,
    // loopback decoder side
    input  wire logic                                      lb_rx_valid,
    input  wire logic [15:0]                               lb_rx_word,
    input  wire logic                                      lb_rx_cmd_sync,
    input  wire logic                                      lb_rx_manch_err,
    input  wire logic                                      lb_rx_parity_err,
    // interrupt
    output logic                                           irq
);
    typedef enum logic [1:0] {MT_IDLE, MT_WRITE, MT_READ, MT_CHECK} mt_state_e;
    typedef enum logic [1:0] {LB_IDLE, LB_SEND, LB_WAIT} lb_state_e;

    mt_state_e                          mt_state_q;
    lb_state_e                          lb_state_q;
    logic                               pin_meta_q, pin_q;
    logic                               mt_en_q, mt_start_q, mt_pass_q, mt_fail_q;
    logic [2:0]                         pat_sel_q;
    logic                               lb_analog_q, lb_sync_q, lb_bus_q;
    logic                               lb_start_q, lb_pass_q, lb_fail_q;
    logic [15:0]                        tx_data_q, rx_data_q, clue_q;
    logic [test_ctrl_pkg::IRQ_BITS-1:0] irq_stat_q, irq_mask_q;
    logic                               wr_pend_q;
    logic [5:0]                         wr_idx_q;
    logic [test_ctrl_pkg::QUAD_AW-1:0]  addr_q;
    logic [1:0]                         pat_q;
    logic [31:0]                        lb_cnt_q;
    logic [test_ctrl_pkg::QUADS-1:0]    quad_err;
    logic                               addr_take, rd_take, ctrl_wr, stat_rd;
    logic                               mt_go, lb_go, mt_done, lb_done;
    logic                               lb_err, lb_timeout;
    logic [5:0]                         addr_idx;
    logic [15:0]                        ctrl_word, rd_word;

    // pin sync: second flop only is read by logic
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            pin_meta_q <= 1'b0;
            pin_q      <= 1'b0;
        end else begin
            pin_meta_q <= test_pin;
            pin_q      <= pin_meta_q;
        end
    end

    // ahb-lite decode; zero wait states, always okay
    assign hreadyout = 1'b1;
    assign hresp     = 1'b0;
    assign addr_idx  = haddr[7:2];
    assign addr_take = hsel && htrans[1] && hready && (haddr[31:8] == 24'h000000);
    assign rd_take   = addr_take && !hwrite;
    assign stat_rd   = rd_take && (addr_idx == test_ctrl_pkg::IDX_IRQ_STATUS);
    assign ctrl_wr   = wr_pend_q && (wr_idx_q == test_ctrl_pkg::IDX_TEST_CONTROL);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_q <= 1'b0;
            wr_idx_q  <= 6'h00;
        end else if (hready) begin
            wr_pend_q <= addr_take && hwrite;
            wr_idx_q  <= addr_idx;
        end
    end

    // [R06] unused bits read zero
    assign ctrl_word = {mt_en_q, 1'b0, pat_sel_q, mt_start_q, mt_pass_q, mt_fail_q, 2'b00,
                        lb_analog_q, lb_sync_q, lb_bus_q, lb_start_q, lb_pass_q, lb_fail_q};

    always_comb begin
        case (addr_idx)
            test_ctrl_pkg::IDX_TEST_CONTROL: rd_word = ctrl_word;
            test_ctrl_pkg::IDX_LOOP_TX_DATA: rd_word = tx_data_q;
            test_ctrl_pkg::IDX_LOOP_RX_DATA: rd_word = rx_data_q;
            test_ctrl_pkg::IDX_FAIL_CLUE:    rd_word = clue_q;
            test_ctrl_pkg::IDX_IRQ_STATUS:   rd_word = {14'h0000, irq_stat_q};
            test_ctrl_pkg::IDX_IRQ_MASK:     rd_word = {14'h0000, irq_mask_q};
            default:                         rd_word = 16'h0000;
        endcase
    end

    // read data is sampled in the address phase so it stands through the data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata <= 32'h00000000;
        end else if (rd_take) begin
            hrdata <= {16'h0000, rd_word};
        end
    end

    // plain host registers
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mt_en_q     <= 1'b0;
            pat_sel_q   <= 3'h0;
            lb_analog_q <= 1'b0;
            lb_sync_q   <= 1'b0;
            lb_bus_q    <= 1'b0;
            tx_data_q   <= test_ctrl_pkg::RST_WORD;
            irq_mask_q  <= 2'h0;
        end else if (wr_pend_q) begin
            if (wr_idx_q == test_ctrl_pkg::IDX_TEST_CONTROL) begin
                mt_en_q     <= hwdata[test_ctrl_pkg::BIT_MT_ENABLE];
                pat_sel_q   <= hwdata[test_ctrl_pkg::BIT_PAT_LO +: 3];
                lb_analog_q <= hwdata[test_ctrl_pkg::BIT_LB_ANALOG];
                lb_sync_q   <= hwdata[test_ctrl_pkg::BIT_LB_SYNC];
                lb_bus_q    <= hwdata[test_ctrl_pkg::BIT_LB_BUS];
            end
            // [R16] host-kept transmit word
            if (wr_idx_q == test_ctrl_pkg::IDX_LOOP_TX_DATA) begin
                tx_data_q <= hwdata[15:0];
            end
            if (wr_idx_q == test_ctrl_pkg::IDX_IRQ_MASK) begin
                irq_mask_q <= hwdata[test_ctrl_pkg::IRQ_BITS-1:0];
            end
        end
    end

    // [R15] start gate uses the stored enable, not the one being written
    assign mt_go = ctrl_wr && hwdata[test_ctrl_pkg::BIT_MT_START] && !mt_start_q
                   && pin_q && mt_en_q;
    // [R10] loop start needs test pin already high
    assign lb_go = ctrl_wr && hwdata[test_ctrl_pkg::BIT_LB_START] && !lb_start_q && pin_q;

    // ---------------- memory self-test ----------------
    // [R04] one compare per quadrant, all in the same cycle
    genvar gq;
    generate
        for (gq = 0; gq < test_ctrl_pkg::QUADS; gq++) begin : g_quad
            assign quad_err[gq] = ram_rdata[gq] != test_ctrl_pkg::pattern(pat_q);
        end
    endgenerate

    assign mt_done = (mt_state_q == MT_CHECK) &&
                     ((|quad_err) || ((addr_q == MT_LAST_ADDR) &&
                                      (pat_q == 2'(test_ctrl_pkg::PAT_COUNT - 1))));
    assign ram_addr  = addr_q;
    assign ram_we    = mt_state_q == MT_WRITE;
    assign ram_re    = mt_state_q == MT_READ;
    assign ram_wdata = test_ctrl_pkg::pattern(pat_q);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mt_state_q <= MT_IDLE;
            addr_q     <= '0;
            pat_q      <= 2'h0;
        end else begin
            case (mt_state_q)
                MT_IDLE: begin
                    addr_q <= '0;
                    pat_q  <= 2'h0;
                    if (mt_go) begin
                        mt_state_q <= MT_WRITE;
                    end
                end
                MT_WRITE: mt_state_q <= MT_READ;
                MT_READ:  mt_state_q <= MT_CHECK;
                MT_CHECK: begin
                    if (mt_done) begin
                        mt_state_q <= MT_IDLE;
                    end else begin
                        mt_state_q <= MT_WRITE;
                        pat_q      <= pat_q + 2'h1;
                        if (pat_q == 2'(test_ctrl_pkg::PAT_COUNT - 1)) begin
                            addr_q <= addr_q + 1'b1;
                        end
                    end
                end
                default: mt_state_q <= MT_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            mt_start_q <= 1'b0;
            mt_pass_q  <= 1'b0;
            mt_fail_q  <= 1'b0;
            clue_q     <= test_ctrl_pkg::RST_WORD;
        end else if (mt_go) begin
            // [R03] flags clear on start
            mt_start_q <= 1'b1;
            mt_pass_q  <= 1'b0;
            mt_fail_q  <= 1'b0;
        end else if (mt_done) begin
            // [R15] start self-clears at completion
            mt_start_q <= 1'b0;
            // [R01] pass when no quadrant mismatched
            mt_pass_q  <= ~|quad_err;
            // [R02] fail on any mismatch
            mt_fail_q  <= |quad_err;
            // [R05] lowest-quadrant address as clue
            if (|quad_err) begin
                clue_q <= {{(16 - test_ctrl_pkg::QUAD_AW){1'b0}}, addr_q};
            end
        end
    end

    // ---------------- loopback test ----------------
    // [R13] any decoder error, wrong sync or data mismatch fails
    assign lb_err = lb_rx_manch_err || lb_rx_parity_err || (lb_rx_cmd_sync != lb_sync_q)
                    || (lb_rx_word != tx_data_q);
    assign lb_timeout = (lb_state_q == LB_WAIT) && (lb_cnt_q == 32'(LB_TIMEOUT - 1));
    assign lb_done    = ((lb_state_q == LB_WAIT) && lb_rx_valid) || lb_timeout;

    assign lb_tx_start    = lb_state_q == LB_SEND;
    assign lb_tx_word     = tx_data_q;
    // [R08] sync type from select bit
    assign lb_tx_cmd_sync = lb_sync_q;
    // [R07] digital mode wraps inside, bus drivers stay off
    assign lb_internal_wrap = (lb_state_q != LB_IDLE) && !lb_analog_q;
    // [R09] bus A when low, bus B when high
    assign lb_bus_a_drive = (lb_state_q != LB_IDLE) && lb_analog_q && !lb_bus_q;
    assign lb_bus_b_drive = (lb_state_q != LB_IDLE) && lb_analog_q && lb_bus_q;

    // a lost word would hang the test, so a timeout ends it as a failure
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lb_state_q <= LB_IDLE;
            lb_cnt_q   <= 32'h00000000;
        end else begin
            case (lb_state_q)
                LB_IDLE: begin
                    lb_cnt_q <= 32'h00000000;
                    if (lb_go) begin
                        lb_state_q <= LB_SEND;
                    end
                end
                LB_SEND: lb_state_q <= LB_WAIT;
                LB_WAIT: begin
                    lb_cnt_q <= lb_cnt_q + 32'h00000001;
                    if (lb_done) begin
                        lb_state_q <= LB_IDLE;
                    end
                end
                default: lb_state_q <= LB_IDLE;
            endcase
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lb_start_q <= 1'b0;
            lb_pass_q  <= 1'b0;
            lb_fail_q  <= 1'b0;
        end else if (lb_go) begin
            // [R14] flags clear on start
            lb_start_q <= 1'b1;
            lb_pass_q  <= 1'b0;
            lb_fail_q  <= 1'b0;
        end else if (lb_done) begin
            // [R11] start self-clears at completion
            lb_start_q <= 1'b0;
            // [R12] pass on clean matching word
            lb_pass_q  <= !lb_timeout && !lb_err;
            // [R18] exactly one result flag
            lb_fail_q  <= lb_timeout || lb_err;
        end
    end

    // [R17] capture received word
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            rx_data_q <= test_ctrl_pkg::RST_WORD;
        end else if ((lb_state_q == LB_WAIT) && lb_rx_valid) begin
            rx_data_q <= lb_rx_word;
        end
    end

    // ---------------- interrupts ----------------
    // set beats the clear-on-read in the same cycle
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            irq_stat_q <= 2'h0;
        end else begin
            irq_stat_q <= (stat_rd ? 2'h0 : irq_stat_q) | {lb_done, mt_done};
        end
    end

    assign irq = |(irq_stat_q & irq_mask_q);

    // ---------------- checks ----------------
    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    chk_mt_one_result: assert property (!(mt_pass_q && mt_fail_q)) // [R18]
        else $error("memtest pass and fail both set");
    chk_lb_one_result: assert property ($fell(lb_start_q) |-> (lb_pass_q ^ lb_fail_q)) // [R18]
        else $error("loopback ended without exactly one result");
    chk_mt_start_clear: assert property ($rose(mt_start_q) |-> !mt_pass_q && !mt_fail_q) // [R03]
        else $error("memtest flags not cleared at start");
    chk_lb_start_clear: assert property ($rose(lb_start_q) |-> !lb_pass_q && !lb_fail_q) // [R14]
        else $error("loopback flags not cleared at start");
    chk_mt_start_gate: assert property ($rose(mt_start_q) |-> $past(pin_q) && $past(mt_en_q)) // [R15]
        else $error("memtest started without pin and enable");
    chk_lb_start_gate: assert property ($rose(lb_start_q) |-> $past(pin_q)) // [R10]
        else $error("loopback started without test pin");
    chk_reserved_bits: assert property (ctrl_word[7:6] == 2'b00) // [R06]
        else $error("unused control bits nonzero");
    chk_mt_fail_clue: assert property (mt_done && |quad_err |=> mt_fail_q && clue_q[12:0] == $past(addr_q)) // [R05]
        else $error("fail clue or flag wrong");
    chk_quad_pass: assert property (mt_done && !(|quad_err) |=> mt_pass_q && !mt_start_q) // [R01]
        else $error("memtest pass not reported");
    chk_lb_digital: assert property (lb_tx_start && !lb_analog_q |-> !lb_bus_a_drive && !lb_bus_b_drive && lb_internal_wrap) // [R07]
        else $error("digital loopback drove a bus");
    chk_lb_bus_sel: assert property (lb_tx_start && lb_analog_q |-> lb_bus_b_drive == lb_bus_q && lb_bus_a_drive != lb_bus_q) // [R09]
        else $error("wrong bus driven");
    chk_lb_word_sync: assert property (lb_tx_start |-> lb_tx_word == tx_data_q && lb_tx_cmd_sync == lb_sync_q) // [R16]
        else $error("transmit word or sync wrong");
    chk_lb_err_fail: assert property (lb_state_q == LB_WAIT && lb_rx_valid && lb_rx_parity_err |=> lb_fail_q && !lb_pass_q) // [R13]
        else $error("parity error not failed");
    chk_lb_rx_store: assert property (lb_state_q == LB_WAIT && lb_rx_valid |=> rx_data_q == $past(lb_rx_word)) // [R17]
        else $error("received word not stored");
    chk_lb_send_wait: assert property ($rose(lb_start_q) |-> lb_tx_start ##1 lb_state_q == LB_WAIT) // [R10]
        else $error("loopback not launched");

    cov_mt_pass: cover property ($rose(mt_pass_q));
    cov_mt_fail: cover property ($rose(mt_fail_q));
    cov_lb_pass: cover property ($rose(lb_pass_q));
    cov_lb_fail: cover property ($rose(lb_fail_q) && lb_analog_q);

endmodule // test_ctrl

// [far_side_model.sv]
// ram quadrants and loopback decoder model facing the test control block
`timescale 1ns/1ps
module far_side_model #(
    parameter int          DELAY      = 20,
    parameter int          FAULT_Q    = 2,
    parameter logic [12:0] FAULT_ADDR = 13'h0003
) (
    // clock and reset
    input  wire logic             hclk,
    input  wire logic             hresetn,
    // ram side
    input  wire logic [12:0]      ram_addr,
    input  wire logic             ram_we,
    input  wire logic             ram_re,
    input  wire logic [15:0]      ram_wdata,
    output logic [3:0][15:0]      ram_rdata,
    // loopback side
    input  wire logic             lb_tx_start,
    input  wire logic [15:0]      lb_tx_word,
    input  wire logic             lb_tx_cmd_sync,
    input  wire logic [2:0]       err_kind,
    output logic                  lb_rx_valid,
    output logic [15:0]           lb_rx_word,
    output logic                  lb_rx_cmd_sync,
    output logic                  lb_rx_manch_err,
    output logic                  lb_rx_parity_err
);
    logic [15:0] wd_q;
    logic [15:0] w_q;
    logic        s_q;
    int          cnt_q;
    // four quadrants answer at once; one stuck bit unless err_kind is 6
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wd_q      <= 16'h0000;
            ram_rdata <= '0;
        end else begin
            if (ram_we) wd_q <= ram_wdata;
            for (int q = 0; q < 4; q++) begin
                // outside a read the lines toggle, so stale data never passes
                ram_rdata[q] <= ram_re ? (wd_q | ((q == FAULT_Q && ram_addr == FAULT_ADDR
                                && err_kind != 3'h6) ? 16'h0001 : 16'h0000)) : ~ram_rdata[q];
            end
        end
    end
    // error kinds: 1 manchester, 2 parity, 3 sync, 4 data, 5 silent
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            cnt_q <= 0;
            w_q <= 16'h0000;
            s_q <= 1'b0;
            lb_rx_valid <= 1'b0;
            lb_rx_word <= 16'h0000;
            lb_rx_cmd_sync <= 1'b0;
            lb_rx_manch_err <= 1'b0;
            lb_rx_parity_err <= 1'b0;
        end else begin
            lb_rx_valid <= 1'b0;
            if (lb_tx_start) begin
                cnt_q <= DELAY;
                w_q <= lb_tx_word;
                s_q <= lb_tx_cmd_sync;
            end else if (cnt_q != 0) cnt_q <= cnt_q - 1;
            if (cnt_q == 1 && err_kind != 3'h5) begin
                lb_rx_valid <= 1'b1;
                lb_rx_word <= w_q ^ {15'h0000, err_kind == 3'h4};
                lb_rx_cmd_sync <= s_q ^ (err_kind == 3'h3);
                lb_rx_manch_err <= err_kind == 3'h1;
                lb_rx_parity_err <= err_kind == 3'h2;
            end else begin
                lb_rx_word <= ~lb_rx_word;
                lb_rx_cmd_sync <= ~lb_rx_cmd_sync;
                lb_rx_manch_err <= 1'b0;
                lb_rx_parity_err <= 1'b0;
            end
        end
    end
endmodule // far_side_model

// [test_ram_bist_and_loopback_test.sv]
// self-checking bench for the self-test and loopback control block
`timescale 1ns/1ps
module test_ram_bist_and_loopback_test;
    localparam logic [5:0] CTL = test_ctrl_pkg::IDX_TEST_CONTROL;
    localparam logic [5:0] STS = test_ctrl_pkg::IDX_IRQ_STATUS;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0, test_pin = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata;
    logic [1:0]  htrans = 2'h0;
    logic [2:0]  hsize = 3'h2, err_kind = 3'h0;
    logic hreadyout, hresp, ram_we, ram_re, lb_tx_start, lb_tx_cmd_sync, lb_bus_a_drive;
    logic lb_bus_b_drive, lb_internal_wrap, lb_rx_valid, lb_rx_cmd_sync, irq;
    logic lb_rx_manch_err, lb_rx_parity_err, cs, ca, cb, ci;
    logic [12:0] ram_addr;
    logic [15:0] ram_wdata, lb_tx_word, lb_rx_word, cw, v;
    logic [3:0][15:0] ram_rdata;
    int errors = 0, checks = 0, cyc = 0;
    test_ctrl #(.LB_TIMEOUT(50), .MT_LAST_ADDR(13'h000F)) test_ctrl_i (.hclk, .hresetn, .hsel,
        .haddr, .htrans,
        .hwrite, .hsize, .hready(hreadyout), .hwdata, .hrdata, .hreadyout, .hresp,
        .test_pin, .ram_addr, .ram_we, .ram_re, .ram_wdata, .ram_rdata, .lb_tx_start,
        .lb_tx_word, .lb_tx_cmd_sync, .lb_bus_a_drive, .lb_bus_b_drive, .lb_internal_wrap,
        .lb_rx_valid, .lb_rx_word, .lb_rx_cmd_sync, .lb_rx_manch_err, .lb_rx_parity_err, .irq);
    far_side_model far_side_model_i (.hclk, .hresetn, .ram_addr, .ram_we, .ram_re,
        .ram_wdata, .ram_rdata, .lb_tx_start, .lb_tx_word, .lb_tx_cmd_sync, .err_kind,
        .lb_rx_valid, .lb_rx_word, .lb_rx_cmd_sync, .lb_rx_manch_err, .lb_rx_parity_err);
    always #2.5 hclk = ~hclk;
    always @(posedge hclk) begin
        cyc <= cyc + 1;
        if (lb_tx_start === 1'b1) begin
            {cw, cs, ca, cb, ci} = {lb_tx_word, lb_tx_cmd_sync, lb_bus_a_drive,
                                    lb_bus_b_drive, lb_internal_wrap};
        end
        // bound well above the whole sequence of tests
        if (cyc == 20000) begin
            errors++;
            results();
        end
    end
    task automatic results();
        $display("checks=%0d errors=%0d", checks, errors);
        if (errors == 0 && checks > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask
    task automatic cmp(input logic [15:0] got, input logic [15:0] exp);
        checks++;
        if (got !== exp) begin
            errors++;
            $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic cmp_pin(input logic got, input logic exp);
        cmp({15'h0000, got}, {15'h0000, exp});
    endtask
    // one single ahb-lite transfer; entered just after a rising edge
    task automatic ahb(input logic w, input logic [5:0] idx, input logic [15:0] wd);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= w;
        haddr <= {24'h000000, idx, 2'h0};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= {16'h0000, wd};
        do @(posedge hclk); while (hreadyout !== 1'b1);
        v = hrdata[15:0];
    endtask
    task automatic chk(input logic [5:0] idx, input logic [15:0] exp);
        ahb(1'b0, idx, 16'h0000);
        cmp(v, exp);
        cmp_pin(hresp, 1'b0);
    endtask
    task automatic wait_idle(input int b);
        int n;
        n = 0;
        do begin ahb(1'b0, CTL, 16'h0000); n++; end while (v[b] !== 1'b0 && n < 300);
        if (v[b] !== 1'b0) errors++;
    endtask
    task automatic t_regs();
        chk(CTL, 16'h0000);
        chk(6'h3F, 16'h0000);
        ahb(1'b1, CTL, 16'h00FC);
        chk(CTL, 16'h0038);
        ahb(1'b1, CTL, 16'h8000);
        ahb(1'b1, CTL, 16'h8400);
        chk(CTL, 16'h8000);
        ahb(1'b1, CTL, 16'h0000);
    endtask
    task automatic t_memtest();
        test_pin <= 1'b1;
        repeat (3) @(posedge hclk);
        ahb(1'b1, CTL, 16'h8400);
        chk(CTL, 16'h8000);
        ahb(1'b1, CTL, 16'h8000);
        for (int r = 0; r < 3; r++) begin
            err_kind <= (r == 2) ? 3'h6 : 3'h0;
            ahb(1'b1, CTL, 16'h8400);
            chk(CTL, 16'h8400);
            wait_idle(10);
            cmp(v, (r == 2) ? 16'h8200 : 16'h8100);
            chk(test_ctrl_pkg::IDX_FAIL_CLUE, 16'h0003);
            chk(STS, 16'h0001);
        end
    endtask
    // cfg is analog, sync, bus; kind selects the far-side error
    task automatic t_loop(input logic [2:0] cfg, input logic [2:0] kind);
        logic [15:0] w;
        logic ok;
        w = 16'h5A3C ^ {13'h0000, cfg} ^ {kind, 13'h0000};
        ok = kind == 3'h0;
        err_kind <= kind;
        ahb(1'b1, test_ctrl_pkg::IDX_IRQ_MASK, {14'h0000, cfg[0], 1'b0});
        ahb(1'b1, test_ctrl_pkg::IDX_LOOP_TX_DATA, w);
        ahb(1'b1, CTL, {10'h000, cfg, 3'b100});
        // the memtest pass flag of the last sweep stays set until its next start
        chk(CTL, {6'h00, 2'b10, 2'b00, cfg, 3'b100});
        wait_idle(2);
        cmp(v, {6'h00, 2'b10, 2'b00, cfg, 1'b0, ok, !ok});
        cmp(cw, w);
        cmp_pin(cs, cfg[1]);
        cmp_pin(ci, !cfg[2]);
        cmp_pin(ca, cfg[2] & !cfg[0]);
        cmp_pin(cb, cfg[2] & cfg[0]);
        if (kind != 3'h5) chk(test_ctrl_pkg::IDX_LOOP_RX_DATA, w ^ {15'h0, kind == 3'h4});
        cmp_pin(irq, cfg[0]);
        chk(STS, 16'h0002);
        cmp_pin(irq, 1'b0);
    endtask
    initial begin
        repeat (5) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_memtest();
        for (int c = 0; c < 8; c++) t_loop(c[2:0], 3'h0);
        for (int k = 1; k < 6; k++) t_loop(3'b101, k[2:0]);
        results();
    end
endmodule // test_ram_bist_and_loopback_test
